// >>> src/aofp_defs.vh
/*
 Shared constants for the converter output format and power control block.
 Assumes inclusion by bare name from the coder and top design files of the block.
*/
`ifndef AOFP_DEFS_VH
`define AOFP_DEFS_VH

// ==========================================================
// Three-level strap codes
`define AOFP_STRAP_LOW 2'h0
`define AOFP_STRAP_FLOAT 2'h1
`define AOFP_STRAP_HIGH 2'h2

// ==========================================================
// Output drive modes
`define AOFP_DRV_CMOS 2'h0
`define AOFP_DRV_DIFF_3MA 2'h1
`define AOFP_DRV_DIFF_2MA 2'h2

// ==========================================================
// Code formats
`define AOFP_FMT_OFFSET 2'h0
`define AOFP_FMT_TWOS 2'h1
`define AOFP_FMT_GRAY 2'h2

// ==========================================================
// Power states
`define AOFP_PWR_NORMAL 2'h0
`define AOFP_PWR_SLEEP 2'h1
`define AOFP_PWR_NAP 2'h2

// ==========================================================
// Sample width and full scale
`define AOFP_DATA_W 12
`define AOFP_FULL_SCALE 12'hFFF
`define AOFP_ZERO_SCALE 12'h000

// ==========================================================
// Recovery times and clock rate
`define AOFP_CLK_MHZ 100
`define AOFP_NAP_WAKE_NS 1000
`define AOFP_SLEEP_WAKE_NS 1000000
`define AOFP_NAP_WAKE_CYC ((`AOFP_NAP_WAKE_NS * `AOFP_CLK_MHZ) / 1000)
`define AOFP_SLEEP_WAKE_CYC ((`AOFP_SLEEP_WAKE_NS * `AOFP_CLK_MHZ) / 1000)

// ==========================================================
// Buffering
`define AOFP_FIFO_DEPTH 16

`endif

// >>> src/aofp_fifo.v
/*
 Synchronous FIFO with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module aofp_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // ==========================================================
    // Storage
    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end

    // ==========================================================
    // Pointers
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// >>> src/aofp_coder.v
/*
 Clamp, over-range detection and output code formatting of one sample.
 Assumes a raw offset-binary word wider than the output, so that values
 above full scale can be seen and saturated.
*/
`timescale 1ns/1ps
`include "aofp_defs.vh"
module aofp_coder #(
    parameter W = 12
) (
    input wire [W:0] raw_i,
    input wire [1:0] fmt_i,
    output reg [W-1:0] code_o,
    output wire over_o
);
    wire [W-1:0] clamped;
    wire [W-1:0] gray;

    // ==========================================================
    // Saturate instead of wrapping past full scale
    assign clamped = raw_i[W] ? {W{1'b1}} : raw_i[W-1:0];
    assign over_o = &clamped;

    // ==========================================================
    // Gray code: top bit kept, lower bits xor with neighbour above
    genvar g;
    generate
        for (g = 0; g < W - 1; g = g + 1) begin : g_gray
            assign gray[g] = clamped[g] ^ clamped[g+1];
        end
    endgenerate
    assign gray[W-1] = clamped[W-1];

    // Formatting works on the clamped word
    always @* begin
        case (fmt_i)
            `AOFP_FMT_OFFSET: begin
                code_o = clamped;
            end
            `AOFP_FMT_TWOS: begin
                code_o = {~clamped[W-1], clamped[W-2:0]};
            end
            `AOFP_FMT_GRAY: begin
                code_o = gray;
            end
            default: begin
                code_o = clamped;
            end
        endcase
    end
endmodule

// >>> src/aofp_top.v
/*
 Output format and power control of a dual-core interleaved converter.
 Straps and serial overrides are plain ports; raw samples arrive one per
 clock when valid; the DDR output is two samples per output clock period.
 Assumes the serial port decoder outside delivers override values and
 write strobes already decoded.
*/
`timescale 1ns/1ps
`include "aofp_defs.vh"
module aofp_top #(
    parameter W = `AOFP_DATA_W,
    parameter FIFO_DEPTH = `AOFP_FIFO_DEPTH,
    parameter NAP_WAKE_CYC = `AOFP_NAP_WAKE_CYC,
    parameter SLEEP_WAKE_CYC = `AOFP_SLEEP_WAKE_CYC
) (
    input wire CLK_I,
    input wire ARST_N_I,
    input wire [1:0] CLOCK_DIVIDE_STRAP_I,
    input wire [1:0] OUTPUT_DRIVE_SELECT_STRAP_I,
    input wire [1:0] POWER_STATE_STRAP_I,
    input wire [1:0] CODE_FORMAT_STRAP_I,
    input wire DIV_WR_I,
    input wire DIV_BY_TWO_I,
    input wire DRV_WR_I,
    input wire [1:0] DRV_MODE_I,
    input wire FMT_WR_I,
    input wire [1:0] FMT_MODE_I,
    input wire PWR_WR_I,
    input wire [1:0] PWR_MODE_I,
    input wire [1:0] CORE_SEL_I,
    input wire SERIAL_SELECT_N_I,
    input wire CALIBRATION_RESET_N_I,
    input wire CAL_DONE_I,
    input wire SAMPLE_VALID_I,
    input wire [W:0] SAMPLE_RAW_I,
    output reg SAMPLE_READY_O,
    output reg [W-1:0] DATA_O,
    output reg DATA_OE_O,
    output reg OUTPUT_SAMPLE_CLOCK_O,
    output reg OUTPUT_SAMPLE_CLOCK_OE_O,
    output reg OVER_RANGE_O,
    output reg OVER_RANGE_OE_O,
    output reg CLK_DIV_TWO_O,
    output reg STRAP_ILLEGAL_O,
    output reg [1:0] DRIVE_MODE_O,
    output reg [1:0] CORE0_PWR_O,
    output reg [1:0] CORE1_PWR_O,
    output reg CONVERTING_O
);
    localparam ST_RUN = 2'h0;
    localparam ST_DOWN = 2'h1;
    localparam ST_WAKE = 2'h2;

    function [1:0] strap_map;
        input [1:0] lvl;
        input [1:0] lo;
        input [1:0] fl;
        input [1:0] hi;
        begin
            case (lvl)
                `AOFP_STRAP_LOW: strap_map = lo;
                `AOFP_STRAP_FLOAT: strap_map = fl;
                `AOFP_STRAP_HIGH: strap_map = hi;
                default: strap_map = fl;
            endcase
        end
    endfunction

    // ==========================================================
    // Strap capture after reset release, then serial override
    reg started_q;
    reg div2_q;
    reg illegal_q;
    reg [1:0] drv_q;
    reg [1:0] fmt_q;
    reg [1:0] pwr0_q;
    reg [1:0] pwr1_q;
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            started_q <= 1'b0;
            div2_q <= 1'b0;
            illegal_q <= 1'b0;
            drv_q <= `AOFP_DRV_DIFF_3MA;
            fmt_q <= `AOFP_FMT_TWOS;
            pwr0_q <= `AOFP_PWR_NORMAL;
            pwr1_q <= `AOFP_PWR_NORMAL;
        end else if (!started_q) begin
            // Straps are sampled once; later pin changes are ignored
            started_q <= 1'b1;
            div2_q <= (CLOCK_DIVIDE_STRAP_I == `AOFP_STRAP_LOW);
            illegal_q <= (CLOCK_DIVIDE_STRAP_I == `AOFP_STRAP_HIGH);
            drv_q <= strap_map(OUTPUT_DRIVE_SELECT_STRAP_I, `AOFP_DRV_CMOS,
                `AOFP_DRV_DIFF_3MA, `AOFP_DRV_DIFF_2MA);
            fmt_q <= strap_map(CODE_FORMAT_STRAP_I, `AOFP_FMT_OFFSET,
                `AOFP_FMT_TWOS, `AOFP_FMT_GRAY);
            pwr0_q <= strap_map(POWER_STATE_STRAP_I, `AOFP_PWR_NORMAL,
                `AOFP_PWR_SLEEP, `AOFP_PWR_NAP);
            pwr1_q <= strap_map(POWER_STATE_STRAP_I, `AOFP_PWR_NORMAL,
                `AOFP_PWR_SLEEP, `AOFP_PWR_NAP);
        end else begin
            if (DIV_WR_I) begin
                div2_q <= DIV_BY_TWO_I;
                illegal_q <= 1'b0;
            end
            if (DRV_WR_I) begin
                drv_q <= DRV_MODE_I;
            end
            if (FMT_WR_I) begin
                fmt_q <= FMT_MODE_I;
            end
            // Only a one-hot core select is honoured
            if (PWR_WR_I && CORE_SEL_I == 2'h1) begin
                pwr0_q <= PWR_MODE_I;
            end
            if (PWR_WR_I && CORE_SEL_I == 2'h2) begin
                pwr1_q <= PWR_MODE_I;
            end
        end
    end

    // ==========================================================
    // Power sequencer; outputs stay off until both cores are awake
    wire any_down;
    wire any_sleep;
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg slept_q;
    reg [19:0] wake_q;
    reg [19:0] wake_d;
    assign any_down = (pwr0_q != `AOFP_PWR_NORMAL) ||
        (pwr1_q != `AOFP_PWR_NORMAL);
    assign any_sleep = (pwr0_q == `AOFP_PWR_SLEEP) ||
        (pwr1_q == `AOFP_PWR_SLEEP);
    always @* begin
        st_d = st_q;
        wake_d = wake_q;
        case (st_q)
            ST_RUN: begin
                if (any_down) begin
                    st_d = ST_DOWN;
                end
            end
            ST_DOWN: begin
                if (!any_down) begin
                    st_d = ST_WAKE;
                    // Sleep recovery counts from the wake write alone
                    if (slept_q) begin
                        wake_d = SLEEP_WAKE_CYC[19:0];
                    end else begin
                        wake_d = NAP_WAKE_CYC[19:0];
                    end
                end
            end
            ST_WAKE: begin
                if (any_down) begin
                    st_d = ST_DOWN;
                end else if (wake_q <= 20'h00001) begin
                    st_d = ST_RUN;
                    wake_d = 20'h00000;
                end else begin
                    wake_d = wake_q - 20'h00001;
                end
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
    end
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_q <= ST_RUN;
            wake_q <= 20'h00000;
            slept_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wake_q <= wake_d;
            if (st_q == ST_RUN) begin
                slept_q <= 1'b0;
            end else if (any_sleep) begin
                slept_q <= 1'b1;
            end
        end
    end
    wire running;
    assign running = started_q && (st_q == ST_RUN) && !any_down;

    // ==========================================================
    // Sample coding and buffering
    wire [W-1:0] coded;
    wire coded_over;
    aofp_coder #(
        .W(W)
    ) u_coder (
        .raw_i(SAMPLE_RAW_I),
        .fmt_i(fmt_q),
        .code_o(coded),
        .over_o(coded_over)
    );

    wire fifo_out_valid;
    wire [W:0] fifo_out_data;
    reg fifo_pop;

    // Ready is a register, so it must promise room one edge ahead;
    // a local copy of the fill level gives that without a fifo port
    reg [4:0] fill_q;
    reg [4:0] fill_d;
    wire take;
    assign take = SAMPLE_VALID_I && SAMPLE_READY_O && running;
    always @* begin
        fill_d = fill_q;
        if (!running) begin
            fill_d = 5'h00;
        end else if (take && !fifo_pop) begin
            fill_d = fill_q + 5'h01;
        end else if (fifo_pop && !take) begin
            fill_d = fill_q - 5'h01;
        end
    end
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fill_q <= 5'h00;
        end else begin
            fill_q <= fill_d;
        end
    end

    aofp_fifo #(
        .WIDTH(W + 1),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .flush_i(!running),
        .in_valid_i(take),
        .in_ready_o(),
        .in_data_i({coded_over, coded}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // ==========================================================
    // DDR output: one word per clock phase, output clock toggles per word
    // The divided clock paces the word rate; a gap holds the last word.
    reg div_ph_q;
    reg ddr_ph_q;
    always @* begin
        fifo_pop = running && fifo_out_valid && (!div2_q || div_ph_q);
    end
    always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            div_ph_q <= 1'b0;
            ddr_ph_q <= 1'b0;
            SAMPLE_READY_O <= 1'b0;
            DATA_O <= {W{1'b0}};
            DATA_OE_O <= 1'b0;
            OUTPUT_SAMPLE_CLOCK_O <= 1'b0;
            OUTPUT_SAMPLE_CLOCK_OE_O <= 1'b0;
            OVER_RANGE_O <= 1'b0;
            OVER_RANGE_OE_O <= 1'b0;
            CLK_DIV_TWO_O <= 1'b0;
            STRAP_ILLEGAL_O <= 1'b0;
            DRIVE_MODE_O <= `AOFP_DRV_DIFF_3MA;
            CORE0_PWR_O <= `AOFP_PWR_NORMAL;
            CORE1_PWR_O <= `AOFP_PWR_NORMAL;
            CONVERTING_O <= 1'b0;
        end else begin
            div_ph_q <= div2_q ? ~div_ph_q : 1'b0;
            SAMPLE_READY_O <= running && (fill_d != FIFO_DEPTH[4:0]);
            CLK_DIV_TWO_O <= div2_q;
            STRAP_ILLEGAL_O <= illegal_q;
            DRIVE_MODE_O <= drv_q;
            CORE0_PWR_O <= pwr0_q;
            CORE1_PWR_O <= pwr1_q;
            CONVERTING_O <= running;
            DATA_OE_O <= running;
            OUTPUT_SAMPLE_CLOCK_OE_O <= running;
            OVER_RANGE_OE_O <= running;
            if (fifo_pop) begin
                DATA_O <= fifo_out_data[W-1:0];
                ddr_ph_q <= ~ddr_ph_q;
                OUTPUT_SAMPLE_CLOCK_O <= ~ddr_ph_q;
                OVER_RANGE_O <= fifo_out_data[W];
            end
            if (!CALIBRATION_RESET_N_I) begin
                ddr_ph_q <= 1'b0;
                OUTPUT_SAMPLE_CLOCK_O <= 1'b0;
            end
            // Calibration holds the flag high over any sample value
            if (!CALIBRATION_RESET_N_I || !CAL_DONE_I) begin
                OVER_RANGE_O <= 1'b1;
            end
        end
    end
endmodule

// >>> tb/aofp_asserts.sv
/*
 Checker for the output format and power control block.
 Assumes binding to aofp_top and straps held steady across each reset.
*/
`timescale 1ns/1ps
module aofp_asserts #(parameter W = 12) (
    input wire CLK_I,
    input wire ARST_N_I,
    input wire [1:0] CLOCK_DIVIDE_STRAP_I,
    input wire [1:0] OUTPUT_DRIVE_SELECT_STRAP_I,
    input wire [1:0] POWER_STATE_STRAP_I,
    input wire DIV_WR_I,
    input wire DIV_BY_TWO_I,
    input wire DRV_WR_I,
    input wire [1:0] DRV_MODE_I,
    input wire PWR_WR_I,
    input wire [1:0] PWR_MODE_I,
    input wire [1:0] CORE_SEL_I,
    input wire CALIBRATION_RESET_N_I,
    input wire CAL_DONE_I,
    input wire SAMPLE_VALID_I,
    input wire [W:0] SAMPLE_RAW_I,
    input wire SAMPLE_READY_O,
    input wire DATA_OE_O,
    input wire OUTPUT_SAMPLE_CLOCK_O,
    input wire OUTPUT_SAMPLE_CLOCK_OE_O,
    input wire OVER_RANGE_O,
    input wire OVER_RANGE_OE_O,
    input wire CLK_DIV_TWO_O,
    input wire STRAP_ILLEGAL_O,
    input wire [1:0] DRIVE_MODE_O,
    input wire [1:0] CORE0_PWR_O,
    input wire [1:0] CORE1_PWR_O
);
// ==========================================================
// Edges since reset release, saturating
reg [2:0] cnt_q;
always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        cnt_q <= 3'h0;
    end else if (cnt_q != 3'h7) begin
        cnt_q <= cnt_q + 3'h1;
    end
end
default clocking @(posedge CLK_I); endclocking
default disable iff (!ARST_N_I);
// ==========================================================
// Assertions
a_strap_load: assert property (cnt_q == 3'h3 |->
    (CLK_DIV_TWO_O == (CLOCK_DIVIDE_STRAP_I == 2'h0)
     || CLOCK_DIVIDE_STRAP_I == 2'h2)
    && STRAP_ILLEGAL_O == (CLOCK_DIVIDE_STRAP_I == 2'h2)
    && DRIVE_MODE_O == OUTPUT_DRIVE_SELECT_STRAP_I
    && CORE0_PWR_O == POWER_STATE_STRAP_I
    && CORE1_PWR_O == POWER_STATE_STRAP_I) else $error("strap load");
a_div_write: assert property (DIV_WR_I |-> ##2
    CLK_DIV_TWO_O == $past(DIV_BY_TWO_I, 2) && !STRAP_ILLEGAL_O)
    else $error("divider write");
a_drv_write: assert property (DRV_WR_I |-> ##2
    DRIVE_MODE_O == $past(DRV_MODE_I, 2)) else $error("drive write");
a_core_write: assert property (PWR_WR_I && CORE_SEL_I == 2'h1 |-> ##2
    CORE0_PWR_O == $past(PWR_MODE_I, 2) && $stable(CORE1_PWR_O))
    else $error("core write");
a_core_refuse: assert property (PWR_WR_I && CORE_SEL_I != 2'h1
    && CORE_SEL_I != 2'h2 |-> ##2 $stable(CORE0_PWR_O)
    && $stable(CORE1_PWR_O)) else $error("refused write applied");
a_down_tristate: assert property ((CORE0_PWR_O | CORE1_PWR_O) != 2'h0
    |-> ##1 !DATA_OE_O && !OVER_RANGE_OE_O && !OUTPUT_SAMPLE_CLOCK_OE_O)
    else $error("outputs driven while down");
a_oe_together: assert property (DATA_OE_O == OVER_RANGE_OE_O
    && DATA_OE_O == OUTPUT_SAMPLE_CLOCK_OE_O) else $error("enables differ");
a_clamp_flag: assert property (SAMPLE_VALID_I && SAMPLE_READY_O
    && SAMPLE_RAW_I[W] && !CLK_DIV_TWO_O |-> ##2 OVER_RANGE_O)
    else $error("over-range flag missing");
a_word_out: assert property (SAMPLE_VALID_I && SAMPLE_READY_O
    && !CLK_DIV_TWO_O |-> ##2 $changed(OUTPUT_SAMPLE_CLOCK_O))
    else $error("output clock did not toggle");
a_cal_flag: assert property ((!CALIBRATION_RESET_N_I || !CAL_DONE_I)
    [*2] |-> OVER_RANGE_O) else $error("calibration flag");
a_cal_clock: assert property (!CALIBRATION_RESET_N_I [*2]
    |-> !OUTPUT_SAMPLE_CLOCK_O) else $error("clock not low in calibration");
a_nap_wake: assert property ((CORE1_PWR_O == 2'h2) ##1
    (CORE1_PWR_O == 2'h0 && CORE0_PWR_O == 2'h0)
    |-> !DATA_OE_O [*3] ##[1:6] DATA_OE_O) else $error("nap wake time");
c_nap_wake: cover property ((CORE1_PWR_O == 2'h2) ##1 (CORE1_PWR_O == 2'h0));
c_clamp: cover property (SAMPLE_VALID_I && SAMPLE_READY_O && SAMPLE_RAW_I[W]);
c_refuse: cover property (PWR_WR_I && CORE_SEL_I == 2'h3);
endmodule
bind aofp_top aofp_asserts #(.W(W)) u_chk (.*);

// >>> tb/aofp_ddr_rx.sv
/*
 Receiver model for the DDR sample bus: one word per output clock half.
 Assumes the output clock toggles at most once per system clock.
*/
`timescale 1ns/1ps
module aofp_ddr_rx (
    input wire clk_i,
    input wire arst_n_i,
    input wire [11:0] data_i,
    input wire or_i,
    input wire oe_i,
    input wire sclk_i
);
logic [12:0] q[$];
logic last_q;
// Released lines float, so a tri-stated bus never yields old data
wire [11:0] bus = oe_i ? data_i : 12'hZZZ;
// Sampling on the system clock avoids racing the data update
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        last_q <= 1'b0;
    end else begin
        last_q <= sclk_i;
        if (oe_i && sclk_i !== last_q) begin
            q.push_back({or_i, bus});
        end
    end
end
endmodule

// >>> tb/test_aofp_top.sv
/*
 Self-checking bench for the output format and power control block.
 Assumes shortened wake counts; the receiver model gathers output words.
*/
`timescale 1ns/1ps
module test_aofp_top;
localparam NAP = 5;
localparam SLP = 20;
localparam logic [12:0] TBL [6] = '{13'h0000, 13'h0001, 13'h0800,
    13'h0FFE, 13'h0FFF, 13'h1234};
reg CLK_I, ARST_N_I, DIV_WR_I, DIV_BY_TWO_I, DRV_WR_I, FMT_WR_I, PWR_WR_I;
reg SERIAL_SELECT_N_I, CALIBRATION_RESET_N_I, CAL_DONE_I, SAMPLE_VALID_I;
reg [1:0] CLOCK_DIVIDE_STRAP_I, OUTPUT_DRIVE_SELECT_STRAP_I, DRV_MODE_I;
reg [1:0] POWER_STATE_STRAP_I, CODE_FORMAT_STRAP_I, FMT_MODE_I;
reg [1:0] PWR_MODE_I, CORE_SEL_I;
reg [12:0] SAMPLE_RAW_I;
wire SAMPLE_READY_O, DATA_OE_O, OUTPUT_SAMPLE_CLOCK_O, OVER_RANGE_O;
wire OUTPUT_SAMPLE_CLOCK_OE_O, OVER_RANGE_OE_O, CLK_DIV_TWO_O;
wire STRAP_ILLEGAL_O, CONVERTING_O;
wire [11:0] DATA_O;
wire [1:0] DRIVE_MODE_O, CORE0_PWR_O, CORE1_PWR_O;
int errors, compares, stalls;
logic [12:0] expq[$];
aofp_top #(.NAP_WAKE_CYC(NAP), .SLEEP_WAKE_CYC(SLP)) dut (.*);
aofp_ddr_rx rx (.clk_i(CLK_I), .arst_n_i(ARST_N_I), .data_i(DATA_O),
    .or_i(OVER_RANGE_O), .oe_i(DATA_OE_O), .sclk_i(OUTPUT_SAMPLE_CLOCK_O));
initial begin
    CLK_I = 0;
    forever #5 CLK_I = ~CLK_I;
end
// ==========================================================
// Shared tasks
task cyc(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
endtask
task cmp(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
        errors++;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
endtask
task results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
task do_reset(input [1:0] div, input [1:0] pwr);
    ARST_N_I = 0;
    CLOCK_DIVIDE_STRAP_I = div;
    POWER_STATE_STRAP_I = pwr;
    cyc(12);
    ARST_N_I = 1;
    cyc(6);
    rx.q.delete();
endtask
// Kind 0 divider, 1 drive, 2 format, 3 power; one pulse then settle
task wr(input int k, input [1:0] v);
    DIV_BY_TWO_I = v[0];
    DRV_MODE_I = v;
    FMT_MODE_I = v;
    PWR_MODE_I = v;
    {DIV_WR_I, DRV_WR_I, FMT_WR_I, PWR_WR_I} = 4'h8 >> k;
    cyc(1);
    {DIV_WR_I, DRV_WR_I, FMT_WR_I, PWR_WR_I} = 4'h0;
    cyc(3);
endtask
// Valid stays up so consecutive calls give back-to-back samples
task send(input [12:0] r, input [1:0] f);
    logic [11:0] b;
    int k;
    b = r[12] ? 12'hFFF : r[11:0];
    expq.push_back({b == 12'hFFF,
        f == 1 ? b ^ 12'h800 : f == 2 ? b ^ (b >> 1) : b});
    SAMPLE_RAW_I = r;
    SAMPLE_VALID_I = 1;
    // Ready read settled before the edge names the edge that takes it
    k = 0;
    while (SAMPLE_READY_O !== 1'b1 && k < 100) begin
        cyc(1);
        k++;
    end
    cyc(1);
    if (k > 0) stalls++;
    if (k == 100) begin
        errors++;
        results;
    end
endtask
task check_rx;
    int k;
    SAMPLE_VALID_I = 0;
    k = 0;
    while (rx.q.size() < expq.size() && k < 200) begin
        cyc(1);
        k++;
    end
    cmp(rx.q.size(), expq.size());
    foreach (expq[i]) if (i < rx.q.size()) cmp(rx.q[i], expq[i]);
    rx.q.delete();
    expq.delete();
endtask
task wake(input int lim);
    int n;
    wr(3, 0);
    n = 3;
    while (DATA_OE_O !== 1'b1 && n < 200) begin
        cyc(1);
        n++;
    end
    cmp(n >= lim && n <= lim + 4, 1);
endtask
// ==========================================================
// Scenarios
task t_straps;
    cmp(CLK_DIV_TWO_O, 0);
    cmp(DRIVE_MODE_O, 2);
    cmp({CORE0_PWR_O, CORE1_PWR_O, DATA_OE_O, CONVERTING_O}, 6'h03);
    $display("straps done");
endtask
task t_format;
    for (int f = 2; f < 5; f++) begin
        if (f > 2) wr(2, f - 3);
        foreach (TBL[i]) send(TBL[i], f % 3);
        check_rx;
    end
    $display("format done");
endtask
task t_fifo;
    for (int m = 2; m >= 0; m--) begin
        wr(1, m);
        cmp(DRIVE_MODE_O, m);
    end
    wr(0, 1);
    cmp(CLK_DIV_TWO_O, 1);
    stalls = 0;
    for (int i = 0; i < 40; i++) send(13'(i * 97), 1);
    check_rx;
    cmp(stalls > 0, 1);
    wr(0, 0);
    $display("fifo done");
endtask
task t_cal;
    CALIBRATION_RESET_N_I = 0;
    cyc(3);
    cmp({OVER_RANGE_O, OUTPUT_SAMPLE_CLOCK_O}, 2'h2);
    CALIBRATION_RESET_N_I = 1;
    CAL_DONE_I = 0;
    cyc(3);
    cmp(OVER_RANGE_O, 1);
    CAL_DONE_I = 1;
    cyc(3);
    rx.q.delete();
    send(13'h0100, 1);
    check_rx;
    $display("calibration done");
endtask
task t_nap;
    do_reset(2'h2, 2'h2);
    cmp(STRAP_ILLEGAL_O, 1);
    cmp({CORE0_PWR_O, CORE1_PWR_O, DATA_OE_O}, 5'h14);
    wr(0, 0);
    cmp(STRAP_ILLEGAL_O, 0);
    CORE_SEL_I = 2'h1;
    wr(3, 0);
    cmp({CORE0_PWR_O, CORE1_PWR_O, DATA_OE_O}, 5'h04);
    CORE_SEL_I = 2'h3;
    wr(3, 1);
    cmp({CORE0_PWR_O, CORE1_PWR_O}, 4'h2);
    CORE_SEL_I = 2'h2;
    wake(NAP);
    send(13'h0ABC, 2);
    check_rx;
    $display("nap done");
endtask
task t_sleep;
    CORE_SEL_I = 2'h1;
    wr(3, 1);
    cmp({CORE0_PWR_O, DATA_OE_O, CONVERTING_O}, 4'h4);
    cyc(30);
    SERIAL_SELECT_N_I = 0;
    cyc(15000);
    wake(SLP);
    wr(3, 1);
    wake(SLP);
    SERIAL_SELECT_N_I = 1;
    $display("sleep done");
endtask
initial begin
    errors = 0;
    compares = 0;
    stalls = 0;
    {DIV_WR_I, DRV_WR_I, FMT_WR_I, PWR_WR_I, SAMPLE_VALID_I} = 5'h00;
    {DIV_BY_TWO_I, DRV_MODE_I, FMT_MODE_I, PWR_MODE_I} = 7'h00;
    CORE_SEL_I = 2'h0;
    SAMPLE_RAW_I = 13'h0000;
    SERIAL_SELECT_N_I = 1;
    CALIBRATION_RESET_N_I = 1;
    CAL_DONE_I = 1;
    OUTPUT_DRIVE_SELECT_STRAP_I = 2'h2;
    CODE_FORMAT_STRAP_I = 2'h2;
    do_reset(2'h1, 2'h0);
    t_straps;
    t_format;
    t_fifo;
    t_cal;
    t_nap;
    t_sleep;
    results;
end
endmodule
